// File: common/claa_pkg.sv
// Package of constants for the chain location address assignment block
package claa_pkg;
  // Frame header and field codes
  localparam logic [7:0] HDR_SESSION = 8'ha1; // Init and finish header
  localparam logic [7:0] ID_BCAST = 8'hff; // Broadcast device id
  localparam logic [7:0] REG_SESSION = 8'hac; // Session register field
  localparam logic [7:0] CMD_ADDR_FIELD = 8'h7f; // Command address field
  localparam logic [7:0] CODE_INIT = 8'h01; // Initialization code
  localparam logic [7:0] CODE_FINISH = 8'h03; // Finish code
  localparam logic [7:0] HDR_ASSIGN = 8'h80; // Assignment write header
  localparam logic [7:0] HDR_READ = 8'hc0; // Address read header
  localparam logic [7:0] HDR_RSP = 8'h00; // One-byte response header
  localparam logic [7:0] REG_NODE_ADDRESS = 8'h3d; // Node address offset
  localparam logic [7:0] NODE_ADDRESS_RST = 8'h00; // Node address reset
  localparam logic [7:0] BCAST_BIT = 8'h20; // Broadcast flag in header
  // CRC constants
  localparam logic [15:0] CRC_POLY_REV = 16'ha001; // Reflected 0x8005
  localparam logic [15:0] CRC_INIT = 16'h0000; // IBM start value
  // Frame gap: bytes idle longer than this restart the parser
  localparam int GAP_US = 100; // Inter-byte timeout in microseconds
  localparam int CLK_MHZ = 20; // Core clock rate
  localparam int GAP_CYC = GAP_US * CLK_MHZ; // Timeout in cycles
  // Bus inactivity during a session, in milliseconds
  localparam int IDLE_MS = 4000; // Inactivity limit
  localparam int IDLE_CYC_DEF = IDLE_MS * 1000 * CLK_MHZ; // Cycles
  // Frame lengths in bytes including CRC
  localparam logic [3:0] LEN_SESSION = 4'h7; // Init and finish
  localparam logic [3:0] LEN_ASSIGN = 4'h6; // Assignment
  localparam logic [3:0] LEN_READ = 4'h5; // Address read
  localparam logic [3:0] LEN_RSP = 4'h5; // Response frame
endpackage : claa_pkg

// File: hw/claa_core.sv
// Slave-side chain location address assignment logic
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Switch closed outside an assignment session
// - Open switch isolates downstream from traffic
// - Init clears address and opens switch
// - Init frame bytes and CRC matched exactly
// - Assignment: 0x80, current id, 0x3d, data
// - Address resets to 0x00, unassigned id
// - Accept only once, only with switch open
// - Close switch right after accepting address
// - Finish frame bytes and CRC matched exactly
// - Finish disables assignment until next init
// - Inactivity in session closes switch, sleeps
// - Stored or per-power-up address flows
// - Response CRC low first, bits reversed
// - CRC-16-IBM over frame, low byte first
// - Broadcast flag with id ff reaches all
// - Address read answered with one-byte response
module claa_core #(
  parameter int IDLE_CYC = claa_pkg::IDLE_CYC_DEF // Session idle limit
) (
  input wire logic clk, // Core clock, 20 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic rx_valid, // Upstream byte strobe
  input wire logic [7:0] rx_data, // Upstream byte
  input wire logic nvm_valid, // Stored address present
  input wire logic [7:0] nvm_address, // Stored address value
  input wire logic ds_valid, // Downstream response byte strobe
  input wire logic [7:0] ds_data, // Downstream response byte
  input wire logic tx_ready, // Upstream transmitter can take a byte
  output logic tx_valid, // Byte toward host valid
  output logic [7:0] tx_data, // Byte toward host
  output logic fwd_valid, // Byte passed to downstream
  output logic [7:0] fwd_data, // Byte passed to downstream
  output logic switch_closed, // Pass-through switch state
  output logic session_active, // Assignment handling enabled
  output logic bus_sleep, // Sleep request after inactivity
  output logic [7:0] node_address // Current node address
);
  typedef enum logic [1:0] {
    CLAA_IDLE = 2'b00, // No response pending
    CLAA_SEND = 2'b01 // Sending response bytes
  } claa_tx_e;

  logic [7:0] buf_q [0:6]; // Received bytes of current frame
  logic [3:0] cnt; // Bytes received
  logic [15:0] gap; // Inter-byte timer
  logic [31:0] idle; // Session inactivity timer
  logic assigned; // Address taken this session
  claa_tx_e tx_st; // Response state
  logic [2:0] tx_idx; // Response byte index
  logic [15:0] crc; // Running receive CRC
  logic [15:0] tcrc; // Running transmit CRC
  logic [7:0] next_buf [0:6];
  logic [3:0] next_cnt;
  logic [15:0] next_gap;
  logic [31:0] next_idle;
  logic next_assigned, next_closed, next_session, next_sleep;
  logic [7:0] next_addr;
  claa_tx_e next_tx_st;
  logic [2:0] next_tx_idx;
  logic [7:0] tx_byte; // Response byte in flight
  logic crc_clr, tcrc_clr, tx_fire;

  // Bit reversal within one byte, used for both response CRC bytes
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
  endfunction : rev8

  // Frame check: folding CRC low then high onto the running value leaves
  // a zero remainder, so the length need not be known while folding
  function automatic logic crc_ok(input logic [15:0] c);
    crc_ok = (c == 16'h0000);
  endfunction : crc_ok
  // Receive CRC runs over every byte, CRC bytes too; a byte that comes
  // while a frame is judged starts the next frame's value
  claa_crc u_rx_crc (
    .clk(clk),
    .rstn(rstn),
    .clear(crc_clr),
    .en(rx_valid),
    .data(rx_data),
    .crc(crc)
  );
  // Transmit CRC covers header, id and data bytes
  claa_crc u_tx_crc (
    .clk(clk),
    .rstn(rstn),
    .clear(tcrc_clr),
    .en(tx_fire && tx_idx < 3'd3),
    .data(tx_byte),
    .crc(tcrc)
  );
  // Response bytes: header, id, data, then reversed CRC low and high
  always_comb begin
    unique case (tx_idx)
      3'd0: tx_byte = claa_pkg::HDR_RSP;
      3'd1: tx_byte = node_address;
      3'd2: tx_byte = node_address;
      3'd3: tx_byte = rev8(tcrc[7:0]);
      default: tx_byte = rev8(tcrc[15:8]);
    endcase
  end
  // Own response has priority; otherwise closed switch relays downstream
  assign tx_fire = (tx_st == CLAA_SEND) && tx_ready;
  assign tx_valid = (tx_st == CLAA_SEND) || (switch_closed && ds_valid);
  assign tx_data = (tx_st == CLAA_SEND) ? tx_byte : ds_data;
  // Open switch cuts every downstream slave off the bus
  assign fwd_valid = switch_closed && rx_valid;
  assign fwd_data = rx_data;
  assign tcrc_clr = (tx_st == CLAA_IDLE);
  // Frame parser, session state and address register
  always_comb begin
    logic done, good;
    logic [7:0] h, id;
    done = 1'b0;
    good = 1'b0;
    h = buf_q[0];
    id = buf_q[1];
    next_buf = buf_q;
    next_cnt = cnt;
    next_gap = gap;
    next_idle = idle;
    next_assigned = assigned;
    next_closed = switch_closed;
    next_session = session_active;
    next_sleep = bus_sleep;
    next_addr = node_address;
    next_tx_st = tx_st;
    next_tx_idx = tx_idx;
    crc_clr = 1'b0;
    // Gap timer restarts a half-received frame
    if (rx_valid) begin
      next_gap = 16'h0000;
      next_sleep = 1'b0;
      if (cnt < 4'd7) next_buf[cnt[2:0]] = rx_data;
      next_cnt = cnt + 4'h1;
    end else if (cnt != 4'h0) begin
      if (gap == 16'(claa_pkg::GAP_CYC)) begin
        next_cnt = 4'h0;
        crc_clr = 1'b1;
      end else begin
        next_gap = gap + 16'h0001;
      end
    end
    // Judge frame once its length is reached; the CRC of read frames is not checked
    if (cnt == claa_pkg::LEN_READ && h == claa_pkg::HDR_READ) begin
      done = 1'b1;
      if (id == node_address && buf_q[2] == claa_pkg::REG_NODE_ADDRESS &&
          tx_st == CLAA_IDLE) begin
        next_tx_st = CLAA_SEND;
        next_tx_idx = 3'd0;
      end
    end else if (cnt == claa_pkg::LEN_ASSIGN && h == claa_pkg::HDR_ASSIGN) begin
      done = 1'b1;
      good = crc_ok(crc);
      if (good && session_active && !assigned && !switch_closed &&
          id == node_address && buf_q[2] == claa_pkg::REG_NODE_ADDRESS) begin
        next_addr = buf_q[3];
        next_assigned = 1'b1;
        next_closed = 1'b1;
      end
    end else if (cnt == claa_pkg::LEN_SESSION &&
                 h == claa_pkg::HDR_SESSION) begin
      done = 1'b1;
      good = crc_ok(crc);
      if (good && (h & claa_pkg::BCAST_BIT) != 8'h00 &&
          id == claa_pkg::ID_BCAST && buf_q[2] == claa_pkg::REG_SESSION &&
          buf_q[3] == claa_pkg::CMD_ADDR_FIELD) begin
        if (buf_q[4] == claa_pkg::CODE_INIT) begin
          next_addr = claa_pkg::NODE_ADDRESS_RST;
          next_assigned = 1'b0;
          next_closed = 1'b0;
          next_session = 1'b1;
          next_idle = 32'h0;
        end else if (buf_q[4] == claa_pkg::CODE_FINISH) begin
          next_session = 1'b0;
          next_closed = 1'b1;
        end
      end
    end else if (cnt == claa_pkg::LEN_SESSION) begin
      done = 1'b1; // Any other frame ends here
    end
    if (done) begin
      next_cnt = rx_valid ? 4'h1 : 4'h0;
      crc_clr = 1'b1;
      if (rx_valid) next_buf[0] = rx_data;
    end
    // Inactivity timer during a session
    if (session_active && next_session) begin
      if (rx_valid) begin
        next_idle = 32'h0;
      end else if (idle == 32'(IDLE_CYC)) begin
        next_session = 1'b0;
        next_closed = 1'b1;
        next_sleep = 1'b1;
      end else begin
        next_idle = idle + 32'h1;
      end
    end
    // Step through response bytes
    if (tx_fire) begin
      if (tx_idx == claa_pkg::LEN_RSP[2:0] - 3'd1) next_tx_st = CLAA_IDLE;
      else next_tx_idx = tx_idx + 3'd1;
    end
  end
  // Register all state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 7; i++) buf_q[i] <= 8'h00;
      cnt <= 4'h0;
      gap <= 16'h0000;
      idle <= 32'h0;
      assigned <= 1'b0;
      switch_closed <= 1'b1;
      session_active <= 1'b0;
      bus_sleep <= 1'b0;
      node_address <= claa_pkg::NODE_ADDRESS_RST;
      tx_st <= CLAA_IDLE;
      tx_idx <= 3'd0;
    end else begin
      buf_q <= next_buf;
      cnt <= next_cnt;
      gap <= next_gap;
      idle <= next_idle;
      assigned <= next_assigned;
      switch_closed <= next_closed;
      session_active <= next_session;
      bus_sleep <= next_sleep;
      // Stored-address flow loads outside a session
      if (nvm_valid && !session_active && !next_session) begin
        node_address <= nvm_address;
      end else begin
        node_address <= next_addr;
      end
      tx_st <= next_tx_st;
      tx_idx <= next_tx_idx;
    end
  end
  a_switch_closes: assert property (@(posedge clk) disable iff (!rstn)
    $rose(assigned) |-> switch_closed && !$past(switch_closed))
    else $error("switch not closed on accept");
  a_open_blocks: assert property (@(posedge clk) disable iff (!rstn)
    !switch_closed |-> !fwd_valid)
    else $error("forwarded with switch open");
  a_idle_closed: assert property (@(posedge clk) disable iff (!rstn)
    !session_active |-> switch_closed)
    else $error("switch open outside session");
  a_one_accept: assert property (@(posedge clk) disable iff (!rstn)
    assigned && $past(assigned) && !$past(nvm_valid)
    |-> $stable(node_address))
    else $error("second assignment taken");
  a_init_opens: assert property (@(posedge clk) disable iff (!rstn)
    $rose(session_active) |-> !switch_closed && !assigned &&
    node_address == claa_pkg::NODE_ADDRESS_RST)
    else $error("session start without open switch and cleared address");
  a_sleep_closes: assert property (@(posedge clk) disable iff (!rstn)
    $rose(bus_sleep) |-> switch_closed && !session_active)
    else $error("sleep entered with switch open or session on");
endmodule : claa_core
`default_nettype wire

// File: hw/claa_crc.sv
// Byte-serial CRC-16-IBM engine
`timescale 1ns/1ps
`default_nettype none
module claa_crc (
  input wire logic clk, // Core clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic clear, // Restart at the initial value
  input wire logic en, // Fold one byte in
  input wire logic [7:0] data, // Byte to fold
  output logic [15:0] crc // Running checksum
);
  logic [15:0] next_crc; // Next checksum

  // Fold eight bits, LSB first, in the reflected form; clear and fold
  // may share a cycle, so a new frame may follow the last with no gap
  always_comb begin
    next_crc = clear ? claa_pkg::CRC_INIT : crc;
    if (en) begin
      next_crc = next_crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
        if (next_crc[0]) begin
          next_crc = (next_crc >> 1) ^ claa_pkg::CRC_POLY_REV;
        end else begin
          next_crc = next_crc >> 1;
        end
      end
    end
  end

  // Register the checksum
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc <= 16'h0000;
    end else begin
      crc <= next_crc;
    end
  end
endmodule : claa_crc
`default_nettype wire

// File: verif/chain_location_address_assign_bench.sv
// Self-checking bench for the chain address assignment slave
`timescale 1ns/1ps
`default_nettype none
module chain_location_address_assign_bench;
  localparam int IDLE = 200; // Short session idle limit
  logic clk, rstn, rx_valid, nvm_valid, ds_valid, tx_ready, tx_valid;
  logic fwd_valid, switch_closed, session_active, bus_sleep, ok;
  logic [7:0] rx_data, nvm_address, ds_data, tx_data, fwd_data;
  logic [7:0] node_address;
  logic [7:0] r [5]; // Reply bytes
  int num_errors = 0;
  int comparisons = 0;
  int fwd_cnt = 0; // Bytes passed downstream
  claa_core #(.IDLE_CYC(IDLE)) dut (.clk(clk), .rstn(rstn),
    .rx_valid(rx_valid), .rx_data(rx_data), .nvm_valid(nvm_valid),
    .nvm_address(nvm_address), .ds_valid(ds_valid), .ds_data(ds_data),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .fwd_valid(fwd_valid), .fwd_data(fwd_data),
    .switch_closed(switch_closed), .session_active(session_active),
    .bus_sleep(bus_sleep), .node_address(node_address));
  claa_host host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // Clock at 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Count forwarded bytes; each must be the host's byte unchanged
  always @(posedge clk) begin
    if (fwd_valid === 1'b1) begin
      fwd_cnt++;
      check("fwd_data", fwd_data, rx_data);
    end
  end
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Let the frame land, then compare the state levels
  task automatic state(logic sw, logic ses, logic [7:0] a);
    repeat (3) @(negedge clk);
    check("switch_closed", {7'h00, switch_closed}, {7'h00, sw});
    check("session_active", {7'h00, session_active}, {7'h00, ses});
    check("node_address", node_address, a);
  endtask : state
  function automatic logic [7:0] rev8(logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
  endfunction : rev8
  task automatic init_f();
    host.send('{8'ha1, 8'hff, 8'hac, 8'h7f, 8'h01, 8'hac, 8'h1c}, 0, 0);
  endtask : init_f
  task automatic asg(logic [7:0] id, logic [7:0] v, bit bad);
    host.send('{8'h80, id, 8'h3d, v}, 1, bad);
  endtask : asg
  // Downstream reply byte; tx shows it only through a closed switch
  task automatic ds_byte(logic [7:0] exp_v);
    @(negedge clk);
    ds_valid = 1'b1;
    ds_data = 8'h5a;
    #1;
    check("tx_valid", {7'h00, tx_valid}, exp_v);
    if (exp_v == 8'h01) check("tx_data", tx_data, 8'h5a);
    @(negedge clk);
    ds_valid = 1'b0;
  endtask : ds_byte
  // Open the chain; open switch isolates downstream
  task automatic t_open();
    int c0;
    state(1'b1, 1'b0, 8'h00);
    check("bus_sleep", {7'h00, bus_sleep}, 8'h00);
    c0 = fwd_cnt;
    init_f();
    state(1'b0, 1'b1, 8'h00);
    check("fwd_init", 8'(fwd_cnt - c0), 8'h07);
    c0 = fwd_cnt;
    asg(8'h00, 8'h01, 1'b1);
    state(1'b0, 1'b1, 8'h00);
    check("fwd_open", 8'(fwd_cnt - c0), 8'h00);
    ds_byte(8'h00);
  endtask : t_open
  // First address is one; a second assignment is ignored
  task automatic t_assign();
    asg(8'h00, 8'h01, 1'b0);
    state(1'b1, 1'b1, 8'h01);
    asg(8'h01, 8'h02, 1'b0);
    state(1'b1, 1'b1, 8'h01);
    ds_byte(8'h01);
  endtask : t_assign
  // Read back with a stalled host
  task automatic t_read();
    logic [7:0] e[$];
    logic [15:0] c;
    e = '{8'h00, 8'h01, 8'h01};
    c = host.crc16(e);
    e.push_back(rev8(c[7:0]));
    e.push_back(rev8(c[15:8]));
    host.send('{8'hc0, 8'h01, 8'h3d}, 1, 0);
    host.get_rsp(3, r, ok);
    check("rsp_done", {7'h00, ok}, 8'h01);
    foreach (r[i]) check("rsp", r[i], e[i]);
  endtask : t_read
  // Finish ends handling; stored address applies outside session
  task automatic t_finish();
    host.send('{8'ha1, 8'hff, 8'hac, 8'h7f, 8'h03, 8'h2d, 8'hdd}, 0, 0);
    state(1'b1, 1'b0, 8'h01);
    asg(8'h01, 8'h07, 1'b0);
    state(1'b1, 1'b0, 8'h01);
    nvm_address = 8'h33;
    nvm_valid = 1'b1;
    state(1'b1, 1'b0, 8'h33);
    nvm_valid = 1'b0;
  endtask : t_finish
  // A silent session closes the switch and sleeps
  task automatic t_idle();
    init_f();
    state(1'b0, 1'b1, 8'h00);
    repeat (IDLE + 10) @(negedge clk);
    check("idle_switch", {7'h00, switch_closed}, 8'h01);
    check("idle_sleep", {7'h00, bus_sleep}, 8'h01);
    check("idle_session", {7'h00, session_active}, 8'h00);
  endtask : t_idle
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
  initial begin
    rstn = 1'b0;
    nvm_valid = 1'b0;
    nvm_address = 8'h00;
    ds_valid = 1'b0;
    ds_data = 8'h00;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    t_open();
    t_assign();
    t_read();
    t_finish();
    t_idle();
    test_done();
  end
endmodule : chain_location_address_assign_bench
`default_nettype wire

// File: verif/claa_host.sv
// Host controller model at the head of the chain
`timescale 1ns/1ps
`default_nettype none
module claa_host (
  input wire logic clk, // Core clock
  output logic rx_valid, // Byte strobe into the slave
  output logic [7:0] rx_data, // Byte into the slave
  input wire logic tx_valid, // Reply byte valid
  input wire logic [7:0] tx_data, // Reply byte
  output logic tx_ready // Host takes the reply byte
);
  // Idle bus at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // Reflected checksum, zero start, over every byte given
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16
  // Frame bytes go out back to back; a whole session fits well inside 4s
  task automatic send(input logic [7:0] f[$], input bit add_crc,
                      input bit bad);
    logic [15:0] c;
    c = crc16(f);
    if (add_crc) begin
      f.push_back(c[7:0]);
      f.push_back(c[15:8] ^ {7'h00, bad});
    end
    foreach (f[i]) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = f[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data; // Released line shows no stale byte
  endtask : send
  // Confirmation read; stall holds off the first bytes
  task automatic get_rsp(input int stall, output logic [7:0] r[5],
                         output bit ok);
    int n;
    int t;
    n = 0;
    t = 0;
    while (n < 5 && t < 200) begin
      @(negedge clk);
      tx_ready = (t >= stall);
      t++;
      #1;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        r[n] = tx_data;
        n++;
      end
    end
    tx_ready = 1'b1;
    ok = (n == 5);
  endtask : get_rsp
endmodule : claa_host
`default_nettype wire
